// ===== src/mpt_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, 0.1 s protection tick
// Notes: fault codes are five bits wide, zero means no fault
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define A_CTRL 4'h0
`define A_SPD 4'h1
`define A_PTC 4'h2
`define A_SCLS 4'h3
`define A_RCLS 4'h4
`define A_HC 4'h5
`define A_COOL 4'h6
`define A_SF 4'h7
`define A_STAT 4'h8
`define A_FCODE 4'h9
`define A_OLC 4'hA

// ****************************************
// Control fields and reset values
// ****************************************
`define C_CFS_EN 0
`define C_INDEP 1
`define C_ZS_HIGH 2
`define CTRL_RST 3'h5
`define SPD_RST 8'h00
`define PTC_RST 3'h0
`define SCLS_RST 6'h0A
`define RCLS_RST 6'h0A
`define HC_RST 7'h3C
`define COOL_RST 14'h012C
`define SF_RST 8'h73

// ****************************************
// Limits
// ****************************************
`define SPD_MAX 8'hFA
`define PTC_MAX 3'h5
`define CLS_MAX 6'h28
`define HC_MAX 7'h63
`define COOL_MIN 14'h000A
`define COOL_MAX 14'h270F
`define PTC_TRIP_OHM 16'h0DAC
`define PTC_CLEAR_OHM 16'h0672
`define OLC_FULL 14'h2710
`define OLC_START_CAP 14'h26AC
`define OL_I2T_K 32'h168

// ****************************************
// Fault codes and controlled-stop eligibility
// ****************************************
`define FC_NONE 5'h00
`define FC_STALL 5'h04
`define FC_PTC 5'h05
`define FC_OL 5'h1C
`define CSTOP_OK 32'h0000_1F50

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_HZ 25000000
`define TICK_MS 100
`define TICK_CYC (`CLK_FREQ_HZ / 1000 * `TICK_MS)
`define TICKS_PER_S 4'hA

`endif

// ===== src/mpt_pkg.sv
// Purpose: types shared by the motor protection block
// Assumes: nothing beyond the constants header
// Notes: each module keeps its state in one struct, except the reset synchroniser rsync_q in the top
package mpt_pkg;

	typedef enum logic [2:0] {MS_STOP, MS_KICK, MS_RAMP, MS_RUN, MS_STOPPING} mot_st_t;
	typedef enum logic [1:0] {F_IDLE, F_CSTOP, F_TRIP} fault_st_t;

	typedef struct packed {
		logic [21:0] cnt;
		logic tick;
	} tick_st_t;

	typedef struct packed {
		logic [13:0] olc;
		logic trip;
	} ol_st_t;

	typedef struct packed {
		logic [2:0] ctl;
		logic [7:0] spd;
		logic [2:0] ptc;
		logic [5:0] scls;
		logic [5:0] rcls;
		logic [6:0] hc;
		logic [13:0] cool;
		logic [7:0] sf;
		logic [15:0] rd;
		logic run;
		logic mon;
		logic [11:0] scnt;
		logic [5:0] pcnt;
		logic plock;
		logic olt;
		fault_st_t st;
		logic [4:0] code;
		logic [5:0] rly;
		logic up_to_speed_relay;
	} top_st_t;

endpackage : mpt_pkg

// ===== src/tick_gen.sv
// Purpose: one-cycle protection tick every DIV clocks
// Assumes: DIV fits in 22 bits
// Notes: restarts from zero after reset
`timescale 1ns/10ps
module tick_gen
	import mpt_pkg::*;
#(
	parameter int unsigned DIV = 2500000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Tick
	output logic tick_o
);
	tick_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == 22'(DIV - 1)) begin
			s_d.cnt = 22'h000000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 22'h000001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;
endmodule : tick_gen

// ===== src/ol_thermal.sv
// Purpose: thermal overload content in hundredths of a percent
// Assumes: current and service factor in percent of full-load current
// Notes: updates once per tick, clear acts at once
`timescale 1ns/10ps
`include "mpt_defs.svh"
module ol_thermal
	import mpt_pkg::*;
(
	// Clock, reset and tick
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	// Control
	input wire logic clear_i,
	input wire logic accum_i,
	input wire logic cap_i,
	input wire logic stopped_i,
	input wire logic [5:0] class_i,
	// Measurements and settings
	input wire logic [9:0] cur_i,
	input wire logic [7:0] derate_i,
	input wire logic [7:0] sf_i,
	input wire logic [6:0] hc_i,
	input wire logic [13:0] cool_i,
	// Result
	output logic [13:0] olc_o,
	output logic trip_o
);
	ol_st_t s_q, s_d;
	logic [31:0] oss, tgt, coolk, step, inc, nxt, dr;

	always_comb begin
		s_d = s_q;
		dr = (derate_i == 8'h00) ? 32'h64 : 32'(derate_i);
		oss = 32'(hc_i) * 32'(cur_i) * 32'h64 / dr; // R16
		tgt = stopped_i ? 32'h0 : ((oss > 32'h2710) ? 32'h2710 : oss); // R18
		coolk = 32'(cool_i) * 32'hC;
		step = 32'h0;
		inc = 32'h0;
		if (tgt > 32'(s_q.olc)) begin
			step = (tgt - 32'(s_q.olc)) / coolk; // R17
			nxt = 32'(s_q.olc) + ((step == 32'h0) ? 32'h1 : step);
		end else if (tgt < 32'(s_q.olc)) begin
			step = (32'(s_q.olc) - tgt) / coolk;
			nxt = 32'(s_q.olc) - ((step == 32'h0) ? 32'h1 : step);
		end else begin
			nxt = 32'(s_q.olc);
		end
		if (accum_i && (cur_i > 10'(sf_i)) && (class_i != 6'h00)) begin
			inc = 32'(cur_i) * 32'(cur_i) / (32'(class_i) * `OL_I2T_K);
		end
		nxt = nxt + inc;
		if (nxt > 32'(`OLC_FULL)) begin
			nxt = 32'(`OLC_FULL); // R14
		end
		if (cap_i && nxt > 32'(`OLC_START_CAP)) begin
			nxt = 32'(`OLC_START_CAP); // R12
		end
		if (clear_i) begin
			s_d.olc = 14'h0000; // R11
		end else if (tick_i) begin
			s_d.olc = nxt[13:0];
		end
		s_d.trip = (s_d.olc >= `OLC_FULL);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign olc_o = s_q.olc;
	assign trip_o = s_q.trip;

	a_start_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
		cap_i && !clear_i |=> s_q.olc <= `OLC_START_CAP || $stable(s_q.olc))
		else $error("content passed the starting cap");
endmodule : ol_thermal

// ===== src/motor_protection_trip_control.sv
// Purpose: fault stop control, stall and thermistor trips, overload class selection
// Assumes: all inputs synchronous to CLK_I; stop sequencer answers with a done pulse
// Notes: register read data appear one cycle after the read strobe
`timescale 1ns/10ps
`include "mpt_defs.svh"

// Notes on behaviour
// R1: Eligible faults run stop action, then trip
// R2: Relays except up-to-speed hold during stop
// R3: Critical faults stop at once, always; an eligible EXT_FAULT_I, or a stall over an overload, in the same cycle takes priority over them
// R4: Stall timer from run; expiry raises 04
// R5: Zero-speed level polarity is configurable
// R6: Thermistor time Off or 1-5 seconds
// R7: Trip above 3.5k, locked until below 1.65k
// R8: Open thermistor trips at once unless Off
// R9: Not independent: running class everywhere
// R10: Independent: starting class in kick, ramp
// R11: Both classes Off clears, no accumulation
// R12: Starting Off: no accumulate, cap 99%
// R13: Starting class Off or 1-40, default 10
// R14: Content held from 0 to 100 percent
// R15: Running class Off or 1-40 at speed
// R16: Steady state from hot/cold ratio formula
// R17: Content approaches steady state by cooling time
// R18: Cooling time: 100% to 1% when stopped
// R19: Fixed per-code controlled-stop flag
// R20: Delays counted in 0.1 s ticks
module motor_protection_trip_control
	import mpt_pkg::*;
#(
	parameter int unsigned TICK_DIV = `TICK_CYC
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	// Register port
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	// Motor and sensors
	input wire logic RUN_CMD_I,
	input wire mot_st_t MOTOR_STATE_I,
	input wire logic ZERO_SPEED_I,
	input wire logic [15:0] PTC_OHM_I,
	input wire logic PTC_OPEN_I,
	input wire logic [9:0] CURRENT_I,
	input wire logic [7:0] DERATE_I,
	// Other fault sources and reset
	input wire logic EXT_FAULT_I,
	input wire logic [4:0] EXT_CODE_I,
	input wire logic FAULT_RESET_I,
	// Stop sequencer
	output logic STOP_REQ_O,
	input wire logic STOP_DONE_I,
	// Relays
	input wire logic [5:0] RELAY_REQ_I,
	input wire logic UTS_REQ_I,
	output logic [5:0] RELAY_O,
	output logic UTS_RELAY_O,
	// Status
	output logic TRIP_O,
	output logic LOCKOUT_O,
	output logic [4:0] FAULT_CODE_O,
	output logic [13:0] OL_CONTENT_O
);
	// ****************************************
	// Reset release and tick
	// ****************************************
	logic [1:0] rsync_q;
	logic rst_n;
	logic tick;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rsync_q <= 2'h0;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_n = rsync_q[1];

	tick_gen #(.DIV(TICK_DIV)) u_tick ( // R20
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.tick_o(tick)
	);

	// ****************************************
	// Overload class selection
	// ****************************************
	top_st_t s_q, s_d;
	logic starting, ol_clear, ol_accum, ol_cap, ol_trip;
	logic [5:0] cls;
	logic [13:0] olc;

	assign starting = (MOTOR_STATE_I == MS_KICK) || (MOTOR_STATE_I == MS_RAMP);
	assign cls = (s_q.ctl[`C_INDEP] && starting) ? s_q.scls : s_q.rcls; // R9 R10 R15
	assign ol_clear = (s_q.scls == 6'h00) && (s_q.rcls == 6'h00); // R11
	assign ol_accum = !ol_clear && (MOTOR_STATE_I != MS_STOP);
	assign ol_cap = s_q.ctl[`C_INDEP] && starting && (s_q.scls == 6'h00); // R12

	ol_thermal u_ol (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.clear_i(ol_clear),
		.accum_i(ol_accum),
		.cap_i(ol_cap),
		.stopped_i(MOTOR_STATE_I == MS_STOP),
		.class_i(cls),
		.cur_i(CURRENT_I),
		.derate_i(DERATE_I),
		.sf_i(s_q.sf),
		.hc_i(s_q.hc),
		.cool_i(s_q.cool),
		.olc_o(olc),
		.trip_o(ol_trip)
	);

	// ****************************************
	// Fault detection
	// ****************************************
	logic zs, stall_ev, ptc_over, ptc_ev, ol_ev, ev, elig;
	logic [4:0] ev_code;
	logic [31:0] cstop_ok;

	assign cstop_ok = `CSTOP_OK;
	assign zs = s_q.ctl[`C_ZS_HIGH] ? ZERO_SPEED_I : !ZERO_SPEED_I; // R5
	assign stall_ev = s_q.mon && zs && tick
		&& (s_q.scnt + 12'h001 >= 12'(s_q.spd) * 12'(`TICKS_PER_S)); // R4
	assign ptc_over = PTC_OHM_I > `PTC_TRIP_OHM;
	assign ptc_ev = (s_q.ptc != 3'h0) && (PTC_OPEN_I // R6 R8
		|| (ptc_over && tick && (s_q.pcnt + 6'h01 >= 6'(s_q.ptc) * 6'(`TICKS_PER_S)))); // R7
	assign ol_ev = ol_trip && !s_q.olt;

	always_comb begin
		ev = 1'b1;
		if (EXT_FAULT_I) begin
			ev_code = EXT_CODE_I;
		end else if (ptc_ev) begin
			ev_code = `FC_PTC;
		end else if (stall_ev) begin
			ev_code = `FC_STALL;
		end else if (ol_ev) begin
			ev_code = `FC_OL;
		end else begin
			ev_code = `FC_NONE;
			ev = 1'b0;
		end
	end
	assign elig = cstop_ok[ev_code]; // R19

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.rd = 16'h0000;
		s_d.run = RUN_CMD_I;
		s_d.olt = ol_trip;
		if (WR_I) begin
			case (ADDR_I)
				`A_CTRL: begin
					s_d.ctl = WDATA_I[2:0];
				end
				`A_SPD: begin
					s_d.spd = (WDATA_I > 16'(`SPD_MAX)) ? `SPD_MAX : WDATA_I[7:0];
				end
				`A_PTC: begin
					s_d.ptc = (WDATA_I > 16'(`PTC_MAX)) ? `PTC_MAX : WDATA_I[2:0]; // R6
				end
				`A_SCLS: begin
					s_d.scls = (WDATA_I > 16'(`CLS_MAX)) ? `CLS_MAX : WDATA_I[5:0]; // R13
				end
				`A_RCLS: begin
					s_d.rcls = (WDATA_I > 16'(`CLS_MAX)) ? `CLS_MAX : WDATA_I[5:0]; // R15
				end
				`A_HC: begin
					s_d.hc = (WDATA_I > 16'(`HC_MAX)) ? `HC_MAX : WDATA_I[6:0];
				end
				`A_COOL: begin
					if (WDATA_I < 16'(`COOL_MIN)) begin
						s_d.cool = `COOL_MIN;
					end else if (WDATA_I > 16'(`COOL_MAX)) begin
						s_d.cool = `COOL_MAX;
					end else begin
						s_d.cool = WDATA_I[13:0];
					end
				end
				`A_SF: begin
					s_d.sf = WDATA_I[7:0];
				end
				default: begin
				end
			endcase
		end
		if (RD_I) begin
			case (ADDR_I)
				`A_CTRL: s_d.rd = {13'h0000, s_q.ctl};
				`A_SPD: s_d.rd = {8'h00, s_q.spd};
				`A_PTC: s_d.rd = {13'h0000, s_q.ptc};
				`A_SCLS: s_d.rd = {10'h000, s_q.scls};
				`A_RCLS: s_d.rd = {10'h000, s_q.rcls};
				`A_HC: s_d.rd = {9'h000, s_q.hc};
				`A_COOL: s_d.rd = {2'h0, s_q.cool};
				`A_SF: s_d.rd = {8'h00, s_q.sf};
				`A_STAT: s_d.rd = {11'h000, s_q.mon, s_q.plock, s_q.st == F_CSTOP,
					s_q.st == F_TRIP, ol_trip};
				`A_FCODE: s_d.rd = {11'h000, s_q.code};
				`A_OLC: s_d.rd = {2'h0, olc};
				default: s_d.rd = 16'h0000;
			endcase
		end
		// Stall monitor
		if (!RUN_CMD_I || s_q.spd == 8'h00) begin
			s_d.mon = 1'b0;
		end else if (RUN_CMD_I && !s_q.run) begin
			s_d.mon = 1'b1; // R4
			s_d.scnt = 12'h000;
		end else if (s_q.mon && !zs) begin
			s_d.mon = 1'b0;
		end else if (stall_ev) begin
			s_d.mon = 1'b0;
		end else if (s_q.mon && tick) begin
			s_d.scnt = s_q.scnt + 12'h001; // R20
		end
		// Thermistor timer and lockout
		if (s_q.ptc == 3'h0 || !ptc_over || ptc_ev) begin
			s_d.pcnt = 6'h00;
		end else if (tick) begin
			s_d.pcnt = s_q.pcnt + 6'h01;
		end
		if (ptc_ev) begin
			s_d.plock = 1'b1; // R7
		end else if (PTC_OHM_I < `PTC_CLEAR_OHM && !PTC_OPEN_I) begin
			s_d.plock = 1'b0;
		end
		// Fault sequencing
		case (s_q.st)
			F_IDLE: begin
				if (ev) begin
					s_d.code = ev_code;
					if (elig && s_q.ctl[`C_CFS_EN]) begin
						s_d.st = F_CSTOP; // R1
					end else begin
						s_d.st = F_TRIP; // R3
					end
				end
			end
			F_CSTOP: begin
				if (ev && !elig) begin
					s_d.code = ev_code;
					s_d.st = F_TRIP; // R3
				end else if (STOP_DONE_I) begin
					s_d.st = F_TRIP; // R1
				end
			end
			F_TRIP: begin
				if (FAULT_RESET_I && !s_q.plock && !ev) begin
					s_d.st = F_IDLE;
					s_d.code = `FC_NONE;
				end
			end
			default: begin
				s_d.st = F_TRIP;
			end
		endcase
		if (s_q.st != F_CSTOP) begin
			s_d.rly = RELAY_REQ_I; // R2
		end
		s_d.up_to_speed_relay = UTS_REQ_I; // R2
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.ctl <= `CTRL_RST;
			s_q.spd <= `SPD_RST;
			s_q.ptc <= `PTC_RST;
			s_q.scls <= `SCLS_RST;
			s_q.rcls <= `RCLS_RST;
			s_q.hc <= `HC_RST;
			s_q.cool <= `COOL_RST;
			s_q.sf <= `SF_RST;
			s_q.st <= F_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign RDATA_O = s_q.rd;
	assign STOP_REQ_O = (s_q.st == F_CSTOP);
	assign TRIP_O = (s_q.st == F_TRIP);
	assign LOCKOUT_O = s_q.plock;
	assign FAULT_CODE_O = s_q.code;
	assign RELAY_O = s_q.rly;
	assign UTS_RELAY_O = s_q.up_to_speed_relay;
	assign OL_CONTENT_O = olc;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!rst_n);

	sequence s_cstop_enter;
		s_q.st == F_IDLE && ev && elig && s_q.ctl[`C_CFS_EN];
	endsequence
	sequence s_stop_done;
		s_q.st == F_CSTOP && STOP_DONE_I && !(ev && !elig);
	endsequence

	a_cstop_enter: assert property (s_cstop_enter |=> STOP_REQ_O && !TRIP_O) // R1
		else $error("eligible fault did not start a controlled stop");
	a_cstop_finish: assert property (s_stop_done |=> TRIP_O && !STOP_REQ_O) // R1
		else $error("controlled stop did not end in a trip");
	a_relay_hold: assert property (STOP_REQ_O |=> $stable(RELAY_O)) // R2
		else $error("relays moved during a controlled stop");
	a_critical_trip: assert property (s_q.st != F_TRIP && ev && !elig |=> TRIP_O) // R3
		else $error("critical fault did not trip at once");
	a_stall_code: assert property (s_q.st == F_IDLE && stall_ev && !EXT_FAULT_I && !ptc_ev
		|=> FAULT_CODE_O == `FC_STALL) // R4
		else $error("stall fault code wrong");
	a_ptc_off: assert property (s_q.ptc == 3'h0 && !LOCKOUT_O |=> !LOCKOUT_O) // R6
		else $error("thermistor lockout while monitoring off");
	a_open_trip: assert property (s_q.ptc != 3'h0 && PTC_OPEN_I |=> LOCKOUT_O) // R8
		else $error("open thermistor not caught at once");
	a_lock_hold: assert property (LOCKOUT_O && PTC_OHM_I >= `PTC_CLEAR_OHM |=> LOCKOUT_O) // R7
		else $error("lockout released above clear level");
	a_ol_clear: assert property (ol_clear |=> OL_CONTENT_O == 14'h0000) // R11
		else $error("content not cleared with both classes off");
	a_lock_set: assert property (ptc_ev |=> LOCKOUT_O) // R7
		else $error("thermistor event did not lock out");
	a_stall_arm: assert property (RUN_CMD_I && !s_q.run && s_q.spd != 8'h00 |=> s_q.mon) // R4
		else $error("stall monitor not armed at run");
	a_uts_follow: assert property (rst_n |=> UTS_RELAY_O == $past(UTS_REQ_I)) // R2
		else $error("up-to-speed relay did not follow its request");
endmodule : motor_protection_trip_control

// ===== tb/mpt_stop_seq.sv
// Purpose: stop-mode sequencer model on the far side of the trip control
// Assumes: one clock, done is a one-cycle pulse
// Notes: delay_i sets how many cycles the stop action takes
`timescale 1ns/10ps
module mpt_stop_seq (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Stop handshake
	input wire logic req_i,
	input wire logic [7:0] delay_i,
	output logic done_o
);
	logic [7:0] cnt_q;
	logic busy_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!req_i) begin
				busy_q <= 1'b0;
				cnt_q <= 8'h00;
			end else if (!busy_q) begin
				busy_q <= 1'b1;
				cnt_q <= delay_i;
			end else if (cnt_q > 8'h01) begin
				cnt_q <= cnt_q - 8'h01;
			end else if (cnt_q == 8'h01) begin
				cnt_q <= 8'h00;
				done_o <= 1'b1;
			end
		end
	end
endmodule : mpt_stop_seq

// ===== tb/motor_protection_trip_control_bench.sv
// Purpose: self-checking bench for the motor protection trip control
// Assumes: short protection tick of 10 clocks
// Notes: stop sequencer model answers controlled stops
`timescale 1ns/10ps
`include "mpt_defs.svh"
module motor_protection_trip_control_bench import mpt_pkg::*;;
	localparam int unsigned TDIV = 10;
	logic clk, nrst, wr, rd, run, zs, popen, ext, frst, stop_req, stop_done;
	logic uts_req, up_to_speed_relay, trip, lock;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, ohm, v;
	logic [9:0] cur;
	logic [7:0] derate, sdly;
	logic [4:0] ecode, fcode;
	logic [5:0] rly_req, rly;
	logic [13:0] olc;
	mot_st_t mst;
	int failures = 0;
	int n_compared = 0;

	motor_protection_trip_control #(.TICK_DIV(TDIV)) uut (.CLK_I(clk), .NRST_I(nrst),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.RUN_CMD_I(run), .MOTOR_STATE_I(mst), .ZERO_SPEED_I(zs), .PTC_OHM_I(ohm),
		.PTC_OPEN_I(popen), .CURRENT_I(cur), .DERATE_I(derate), .EXT_FAULT_I(ext),
		.EXT_CODE_I(ecode), .FAULT_RESET_I(frst), .STOP_REQ_O(stop_req),
		.STOP_DONE_I(stop_done), .RELAY_REQ_I(rly_req), .UTS_REQ_I(uts_req),
		.RELAY_O(rly), .UTS_RELAY_O(up_to_speed_relay), .TRIP_O(trip), .LOCKOUT_O(lock),
		.FAULT_CODE_O(fcode), .OL_CONTENT_O(olc));
	mpt_stop_seq partner (.clk_i(clk), .rst_n_i(nrst), .req_i(stop_req), .delay_i(sdly),
		.done_o(stop_done));

	// ****************************************
	// Helpers
	// ****************************************
	always #20 clk = ~clk;

	task automatic final_report;
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic wait_trip(input int lim);
		int i;
		for (i = 0; i < lim && trip !== 1'b1; i++)
			cyc(1);
		if (trip !== 1'b1) begin
			failures++;
			$display("[ERR] trip wait expired");
			final_report();
		end
	endtask : wait_trip

	task automatic freset;
		@(posedge clk);
		frst <= 1'b1;
		@(posedge clk);
		frst <= 1'b0;
		cyc(1);
	endtask : freset

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		logic [15:0] exp [8];
		exp = '{16'h0005, 16'h0000, 16'h0000, 16'h000A, 16'h000A, 16'h003C, 16'h012C,
			16'h0073};
		for (int a = 0; a < 8; a++) begin
			rd_reg(a[3:0], v);
			chk("reset_reg", v, exp[a]);
		end
		rd_reg(4'hF, v);
		chk("unmapped", v, 16'h0000);
		wr_reg(`A_SPD, 16'hFFFF);
		rd_reg(`A_SPD, v);
		chk("spd_clamp", v, 16'h00FA);
		wr_reg(`A_SPD, 16'h0000);
	endtask : t_regs

	task automatic t_faults;
		logic elig;
		for (int c = 1; c < 13; c++) begin
			elig = 1'(`CSTOP_OK >> c);
			@(posedge clk);
			sdly <= (c == 4) ? 8'h02 : 8'h1E;
			ext <= 1'b1;
			ecode <= c[4:0];
			rly_req <= 6'h15;
			uts_req <= 1'b0;
			@(posedge clk);
			ext <= 1'b0;
			rly_req <= 6'h2A;
			uts_req <= 1'b1;
			#1;
			chk("stop_req", 16'(stop_req), 16'(elig));
			chk("trip_now", 16'(trip), 16'(!elig));
			chk("code", 16'(fcode), 16'(c));
			cyc(1);
			chk("uts_follow", 16'(up_to_speed_relay), 16'h0001);
			if (elig) begin
				chk("relay_hold", 16'(rly), 16'h0015);
				chk("no_trip_yet", 16'(trip), 16'h0000);
				wait_trip(100);
				chk("stop_end", 16'(stop_req), 16'h0000);
			end
			freset();
			chk("trip_clear", 16'(trip), 16'h0000);
			chk("code_clear", 16'(fcode), 16'h0000);
		end
	endtask : t_faults

	task automatic t_ptc;
		wr_reg(`A_PTC, 16'h0002);
		@(posedge clk);
		popen <= 1'b1;
		cyc(3);
		chk("open_trip", 16'(trip), 16'h0001);
		chk("open_code", 16'(fcode), 16'(`FC_PTC));
		chk("open_lock", 16'(lock), 16'h0001);
		rd_reg(`A_STAT, v);
		chk("stat_lock", v, 16'h000A);
		popen <= 1'b0;
		ohm <= 16'h0BB8;
		cyc(3);
		chk("lock_hold", 16'(lock), 16'h0001);
		freset();
		chk("reset_refused", 16'(trip), 16'h0001);
		ohm <= 16'h03E8;
		cyc(3);
		chk("lock_free", 16'(lock), 16'h0000);
		freset();
		wr_reg(`A_PTC, 16'h0001);
		ohm <= 16'h0E10;
		cyc(5);
		chk("hot_delay", 16'(trip), 16'h0000);
		wait_trip(200);
		chk("hot_code", 16'(fcode), 16'(`FC_PTC));
		ohm <= 16'h03E8;
		cyc(3);
		freset();
		wr_reg(`A_PTC, 16'h0000);
		popen <= 1'b1;
		cyc(20);
		chk("ptc_off", 16'(trip), 16'h0000);
		popen <= 1'b0;
	endtask : t_ptc

	task automatic t_stall;
		wr_reg(`A_CTRL, 16'h0004);
		wr_reg(`A_SPD, 16'h0001);
		zs <= 1'b1;
		run <= 1'b1;
		cyc(80);
		chk("stall_early", 16'(trip), 16'h0000);
		wait_trip(60);
		chk("stall_code", 16'(fcode), 16'(`FC_STALL));
		rd_reg(`A_FCODE, v);
		chk("fcode_reg", v, 16'(`FC_STALL));
		run <= 1'b0;
		freset();
		wr_reg(`A_CTRL, 16'h0000);
		run <= 1'b1;
		cyc(150);
		chk("zs_polarity", 16'(trip), 16'h0000);
		run <= 1'b0;
		zs <= 1'b0;
		cyc(2);
		run <= 1'b1;
		wait_trip(120);
		chk("zs_low_stall", 16'(fcode), 16'(`FC_STALL));
		run <= 1'b0;
		zs <= 1'b1;
		freset();
	endtask : t_stall

	task automatic t_ol;
		wr_reg(`A_SCLS, 16'h0001);
		wr_reg(`A_RCLS, 16'h0001);
		mst <= MS_KICK;
		cur <= 10'h258;
		run <= 1'b1;
		wait_trip(400);
		chk("ol_code", 16'(fcode), 16'(`FC_OL));
		chk("ol_range", 16'(olc <= `OLC_FULL), 16'h0001);
		wr_reg(`A_CTRL, 16'h0002);
		wr_reg(`A_SCLS, 16'h0000);
		cyc(25);
		chk("start_cap", 16'(olc), 16'(`OLC_START_CAP));
		wr_reg(`A_RCLS, 16'h0000);
		cyc(2);
		chk("ol_clear", 16'(olc), 16'h0000);
		cyc(40);
		chk("ol_none", 16'(olc), 16'h0000);
		wr_reg(`A_RCLS, 16'h0001);
		cyc(40);
		chk("kick_no_i2t", 16'(olc < 14'h0064), 16'h0001);
		mst <= MS_RUN;
		cyc(40);
		chk("run_i2t", 16'(olc >= 14'h07D0), 16'h0001);
	endtask : t_ol

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{wr, rd, run, zs, popen, ext, frst, uts_req} = '0;
		addr = 4'h0;
		wdata = 16'h0000;
		ohm = 16'h03E8;
		cur = 10'd0;
		derate = 8'h64;
		sdly = 8'h02;
		ecode = 5'h00;
		rly_req = 6'h00;
		mst = MS_STOP;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_faults();
		t_ptc();
		t_stall();
		t_ol();
		final_report();
	end
endmodule : motor_protection_trip_control_bench
